/* File: hw/tsw_watchdog_unit.sv */
// two-stage watchdog with apb registers
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "tsw_params.svh"
module tsw_watchdog_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic interrupt,
  output tsw_pkg::tsw_int_t intRoute,
  output logic timeout_reset_out_n
);
  import tsw_pkg::*;

  //================================================================
  // declarations
  tsw_ctrl_t ctrl_q;
  logic [34:0] pre1_q;
  logic [34:0] pre2_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [34:0] cnt_q;
  tsw_state_t state_q;
  logic [7:0] tickDiv_q;
  logic tick_q;
  logic [4:0] rstCnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  tsw_int_t route_q;
  logic rstOut_q;
  logic setup;
  logic wrEn;
  logic reloadWr;
  logic exp1;
  logic exp2;
  logic [1:0] evt;
  logic [1:0] clr;

  // cap a preload at ten minutes; a zero load is raised to one tick
  // so the stage still ends. loads below one millisecond are kept:
  // software owns the lower end, and short stages stay usable
  function automatic logic [34:0] clampLoad(input logic [34:0] v);
    if (v < `TSW_LOAD_FLOOR) begin
      clampLoad = `TSW_LOAD_FLOOR;
    end else if (v > 35'(`TSW_MAX_TICKS)) begin
      clampLoad = 35'(`TSW_MAX_TICKS);
    end else begin
      clampLoad = v;
    end
  endfunction

  function automatic logic isOff(input logic [7:0] a,
                                 input logic [7:0] off);
    isOff = (a == off);
  endfunction

  //================================================================
  // apb slave: decode in setup, answer in first access cycle
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready_q & pwrite;
  assign reloadWr = wrEn & isOff(paddr, `TSW_OFF_RELOAD);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup & ~pready_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        `TSW_OFF_CTRL: prdata_q <= {29'h0, ctrl_q};
        `TSW_OFF_PRE1_LO: prdata_q <= pre1_q[31:0];
        `TSW_OFF_PRE1_HI: prdata_q <= {29'h0, pre1_q[34:32]};
        `TSW_OFF_PRE2_LO: prdata_q <= pre2_q[31:0];
        `TSW_OFF_PRE2_HI: prdata_q <= {29'h0, pre2_q[34:32]};
        `TSW_OFF_RELOAD: prdata_q <= 32'h0000_0000;
        `TSW_OFF_STATUS: prdata_q <= {30'h0, status_q};
        `TSW_OFF_MASK: prdata_q <= {30'h0, mask_q};
        `TSW_OFF_COUNT: prdata_q <= cnt_q[31:0];
        `TSW_OFF_STAGE: prdata_q <= {28'h0, state_q};
        default: pslverr_q <= 1'b1;
      endcase
    end
  end

  //================================================================
  // software registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `TSW_CTRL_RST;
      mask_q <= `TSW_MASK_RST;
    end else if (wrEn) begin
      if (isOff(paddr, `TSW_OFF_CTRL)) begin
        ctrl_q <= tsw_ctrl_t'(pwdata[2:0]);
      end
      if (isOff(paddr, `TSW_OFF_MASK)) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre1_q <= `TSW_PRE_RST;
      pre2_q <= `TSW_PRE_RST;
    end else if (wrEn) begin
      unique case (paddr)
        `TSW_OFF_PRE1_LO: pre1_q[31:0] <= pwdata;
        `TSW_OFF_PRE1_HI: pre1_q[34:32] <= pwdata[2:0];
        `TSW_OFF_PRE2_LO: pre2_q[31:0] <= pwdata;
        `TSW_OFF_PRE2_HI: pre2_q[34:32] <= pwdata[2:0];
        default: pre1_q <= pre1_q;
      endcase
    end
  end

  //================================================================
  // microsecond tick; the counter runs in ticks, not clocks, so
  // ten minutes still fit in 35 bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickDiv_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (tickDiv_q == 8'(`TSW_TICK_CYC - 1)) begin
      tickDiv_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      tickDiv_q <= tickDiv_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  //================================================================
  // two-stage counter
  assign exp1 = (state_q == ST_FIRST) & tick_q & (cnt_q == 35'h1)
    & ~reloadWr;
  assign exp2 = (state_q == ST_SECOND) & tick_q & (cnt_q == 35'h1)
    & ~reloadWr;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 35'h0;
      rstCnt_q <= 5'h00;
    end else if (!ctrl_q.enable) begin
      state_q <= ST_IDLE;
      cnt_q <= 35'h0;
      rstCnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_FIRST;
          cnt_q <= clampLoad(pre1_q);
        end
        ST_FIRST, ST_SECOND: begin
          if (reloadWr) begin
            state_q <= ST_FIRST;
            cnt_q <= clampLoad(pre1_q);
          end else if (exp1) begin
            state_q <= ST_SECOND;
            cnt_q <= clampLoad(pre2_q);
          end else if (exp2) begin
            // the expiry cycle is already the first low cycle
            state_q <= ST_FIRE;
            rstCnt_q <= 5'(`TSW_RST_CYC - 2);
          end else if (tick_q) begin
            cnt_q <= cnt_q - 35'h1;
          end
        end
        ST_FIRE: begin
          // pulse ends, then the unit restarts from the first stage
          if (rstCnt_q == 5'h00) begin
            state_q <= ST_IDLE;
          end else begin
            rstCnt_q <= rstCnt_q - 5'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  //================================================================
  // sticky status, write one to clear; a new event beats the clear
  assign evt = {exp2, exp1};
  assign clr = (wrEn & isOff(paddr, `TSW_OFF_STATUS)) ?
    pwdata[1:0] : 2'b00;
  assign status_d = (status_q & ~clr) | evt;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 2'b00;
    end else begin
      status_q <= status_d;
    end
  end

  //================================================================
  // outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
      route_q <= 3'b000;
    end else begin
      irq_q <= |(status_q & mask_q);
      route_q.intIrq <= status_q[0] & mask_q[0]
        & (ctrl_q.intSel == SEL_IRQ);
      route_q.intSmi <= status_q[0] & mask_q[0]
        & (ctrl_q.intSel == SEL_SMI);
      route_q.intSci <= status_q[0] & mask_q[0]
        & (ctrl_q.intSel == SEL_SCI);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstOut_q <= 1'b1;
    end else begin
      rstOut_q <= ~((state_q == ST_FIRE) | exp2);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign interrupt = irq_q;
  assign intRoute = route_q;
  assign timeout_reset_out_n = rstOut_q;

  //================================================================
  // checks
  stage_load_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_IDLE && ctrl_q.enable) |=>
      state_q == ST_FIRST && cnt_q == clampLoad($past(pre1_q)))
    else $error("first stage not loaded");

  first_expiry_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    exp1 |=> status_q[0] ##1 (irq_q || !$past(mask_q[0])))
    else $error("first expiry not flagged");

  second_stage_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    exp1 && ctrl_q.enable |=>
      state_q == ST_SECOND && cnt_q == clampLoad($past(pre2_q)))
    else $error("second stage not loaded");

  reset_pulse_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    exp2 && ctrl_q.enable |=> !timeout_reset_out_n[*8])
    else $error("reset pulse too short");

  int_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $countones(intRoute) <= 1 &&
      (!intRoute.intSmi || $past(ctrl_q.intSel) == SEL_SMI))
    else $error("interrupt routed wrongly");

  count_span_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_q == ST_FIRST |->
      cnt_q <= 35'(`TSW_MAX_TICKS) && cnt_q != 35'h0)
    else $error("count outside span");

  reset_level_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !timeout_reset_out_n |-> $past(state_q) == ST_FIRE || $past(exp2))
    else $error("reset without expiry");

  host_reload_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reloadWr && ctrl_q.enable && state_q != ST_IDLE
      && state_q != ST_FIRE |=> state_q == ST_FIRST)
    else $error("reload ignored");

  set_wins_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    exp1 && clr[0] |=> status_q[0])
    else $error("event lost to clear");

  apb_answer_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer timing");

  first_cov: cover property (@(posedge core_clk) exp1);
  fire_cov: cover property (@(posedge core_clk) $fell(rstOut_q));
  reload_cov: cover property (
    @(posedge core_clk) reloadWr && state_q == ST_SECOND);
endmodule

/* File: hw/tsw_params.svh */
// constants and register map of the two-stage watchdog
//==================================================================
// What this block does
// - enable loads 35-bit counter from first preload
// - first-stage zero without reload raises interrupt
// - then reload second preload, count second stage
// - second-stage expiry generates system reset
// - first-stage interrupt routed as IRQ, SMI, SCI
// - timeout spans one microsecond tick to ten minutes
// - reset output is active low
`ifndef TSW_PARAMS_SVH
`define TSW_PARAMS_SVH
//==================================================================
// register byte offsets
`define TSW_OFF_CTRL 8'h00
`define TSW_OFF_PRE1_LO 8'h04
`define TSW_OFF_PRE1_HI 8'h08
`define TSW_OFF_PRE2_LO 8'h0C
`define TSW_OFF_PRE2_HI 8'h10
`define TSW_OFF_RELOAD 8'h14
`define TSW_OFF_STATUS 8'h18
`define TSW_OFF_MASK 8'h1C
`define TSW_OFF_COUNT 8'h20
`define TSW_OFF_STAGE 8'h24
//==================================================================
// field positions
`define TSW_CTRL_EN_BIT 0
`define TSW_CTRL_SEL_LSB 1
`define TSW_ST_FIRST_BIT 0
`define TSW_ST_SECOND_BIT 1
//==================================================================
// reset values
`define TSW_CTRL_RST 3'h0
`define TSW_PRE_RST 35'h0_0000_03E8
`define TSW_MASK_RST 2'h0
//==================================================================
// timing: one tick per microsecond
`define TSW_CLK_PS 5000
`define TSW_TICK_PS 1000000
`define TSW_TICK_CYC (`TSW_TICK_PS / `TSW_CLK_PS)
`define TSW_MIN_MS 1
`define TSW_MAX_MIN 10
`define TSW_MIN_TICKS (`TSW_MIN_MS * 1000)
`define TSW_MAX_TICKS (`TSW_MAX_MIN * 60 * 1000000)
`define TSW_RST_CYC 16
`define TSW_LOAD_FLOOR 35'h0_0000_0001
`endif

/* File: hw/tsw_pkg.sv */
// types shared by the two-stage watchdog
package tsw_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_FIRE = 4'b1000
  } tsw_state_t;
  typedef enum logic [1:0] {
    SEL_IRQ = 2'b00,
    SEL_SMI = 2'b01,
    SEL_SCI = 2'b10
  } tsw_sel_t;
  typedef struct packed {
    tsw_sel_t intSel;
    logic enable;
  } tsw_ctrl_t;
  typedef struct packed {
    logic intIrq;
    logic intSmi;
    logic intSci;
  } tsw_int_t;
endpackage

/* File: sim/tsw_host_model.sv */
// apb host model that programs and refreshes the watchdog
`timescale 1ns/1ps
`include "tsw_params.svh"
module tsw_host_model (
  input wire logic core_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000
);
  //==================================================================
  // one apb transfer, request held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [32:0] r);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  //==================================================================
  // refresh well inside the timeout so the board never resets
  task automatic refresh();
    logic [32:0] r;
    xfer(`TSW_OFF_RELOAD, 1'b1, 32'h0000_0001, r);
  endtask
endmodule

/* File: sim/tb_tsw_watchdog_unit.sv */
// self-checking bench for the two-stage watchdog
`timescale 1ns/1ps
`include "tsw_params.svh"
module tb_tsw_watchdog_unit;
  import tsw_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, interrupt, rstOutN;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd, pre1, pre2;
  tsw_int_t intRoute;
  logic [32:0] expQ[$];
  int mismatches = 0;
  int checkCount = 0;
  int cyc = 0;
  int t0, n;

  tsw_watchdog_unit uut (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .interrupt(interrupt), .intRoute(intRoute),
    .timeout_reset_out_n(rstOutN));
  tsw_host_model host (.core_clk(core_clk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial forever #2.5 core_clk = ~core_clk;
  //==================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic endSim();
    $display("mismatches %0d checks %0d", mismatches, checkCount);
    if (mismatches == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmpRead(input logic [7:0] a, input logic [32:0] e,
      input logic [32:0] s);
    checkCount++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR read %h expected %h seen %h", a, e, s);
    end
  endtask
  task automatic cmpLvl(input string nm, input logic [2:0] e,
      input logic [2:0] s);
    checkCount++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    host.xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    expQ.push_back(e);
    host.xfer(a, 1'b0, 32'h0000_0000, r);
  endtask
  //==================================================================
  // monitor and hang guard; short preloads keep the run near
  // ten thousand cycles, the ceiling allows three times that
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 32'h0000_7530) begin
      mismatches++;
      endSim();
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0 && expQ.size() > 0)
      cmpRead(paddr, expQ.pop_front(), {pslverr, prdata});
  end
  //==================================================================
  // main sequence
  initial begin
    rnd = xs(32'h0000_004E);
    pre1 = 32'h0000_0014 + {29'h0, rnd[2:0]};
    pre2 = 32'h0000_0010 + {29'h0, rnd[5:3]};
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    cmpLvl("reset out idle", 3'b001, {2'b00, rstOutN});
    rd(`TSW_OFF_CTRL, 33'h0_0000_0000);
    rd(`TSW_OFF_PRE1_LO, 33'h0_0000_03E8);
    rd(`TSW_OFF_STAGE, 33'h0_0000_0001);
    rd(8'h28, 33'h1_0000_0000);
    wr(`TSW_OFF_PRE1_LO, pre1);
    wr(`TSW_OFF_PRE1_HI, 32'h0000_0000);
    wr(`TSW_OFF_PRE2_LO, pre2);
    wr(`TSW_OFF_MASK, 32'h0000_0003);
    wr(`TSW_OFF_CTRL, 32'h0000_0001);
    rd(`TSW_OFF_STAGE, 33'h0_0000_0002);
    repeat (32'h0000_07D0) @(posedge core_clk);
    host.refresh();
    t0 = cyc;
    while (interrupt !== 1'b1) @(posedge core_clk);
    n = cyc - t0;
    cmpLvl("first stage span", 3'b001, {2'b00, n >= (pre1 - 1) * 200 &&
      n <= pre1 * 200 + 8});
    t0 = cyc;
    cmpLvl("route irq", 3'b100, intRoute);
    rd(`TSW_OFF_STAGE, 33'h0_0000_0004);
    rd(`TSW_OFF_STATUS, 33'h0_0000_0001);
    for (int s = 1; s < 4; s++) begin
      wr(`TSW_OFF_CTRL, {29'h0, 2'(s), 1'b1});
      repeat (2) @(posedge core_clk);
      cmpLvl("route select", 3'b100 >> s, intRoute);
    end
    wr(`TSW_OFF_CTRL, 32'h0000_0001);
    wr(`TSW_OFF_MASK, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    cmpLvl("masked irq", 3'b000, {2'b00, interrupt});
    wr(`TSW_OFF_MASK, 32'h0000_0003);
    wr(`TSW_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    cmpLvl("cleared irq", 3'b000, {2'b00, interrupt});
    rd(`TSW_OFF_STATUS, 33'h0_0000_0000);
    while (rstOutN !== 1'b0) @(posedge core_clk);
    n = cyc - t0;
    cmpLvl("second stage span", 3'b001, {2'b00, n >= (pre2 - 1) * 200 &&
      n <= pre2 * 200 + 8});
    n = 0;
    while (rstOutN === 1'b0) begin
      @(posedge core_clk);
      n++;
    end
    cmpLvl("reset low cycles", 3'b001, {2'b00, n == 16});
    rd(`TSW_OFF_STATUS, 33'h0_0000_0002);
    cmpLvl("second irq", 3'b001, {2'b00, interrupt});
    rd(`TSW_OFF_STAGE, 33'h0_0000_0002);
    wr(`TSW_OFF_CTRL, 32'h0000_0000);
    rd(`TSW_OFF_STAGE, 33'h0_0000_0001);
    rd(`TSW_OFF_COUNT, 33'h0_0000_0000);
    endSim();
  end
endmodule
